// [hw/sac_conv_ctrl.sv]
// Conversion sequencing and readout selection for three channel pairs.
`timescale 1ns/1ps
module sac_conv_ctrl
  import sac_pkg::*;
(
  input  wire logic              clock,
  input  wire logic              nrst,
  input  wire logic              clk_en,
  input  wire logic              start_pair_a,
  input  wire logic              start_pair_b,
  input  wire logic              start_pair_c,
  input  wire logic              soft_mode,
  input  wire logic              interface_select,
  input  wire logic              word_byte_sel,
  input  wire logic              high_byte_first,
  input  wire logic              cs_n,
  input  wire logic              rd_n,
  input  wire logic              wr_n,
  input  wire logic [DW-1:0]     db_in,
  input  wire logic              buffer_disable_pin,
  input  wire logic [NCH*DW-1:0] sample_data,
  input  wire logic              sclk,
  input  wire logic              daisy_en,
  input  wire logic              daisy_in,
  output logic                   busy,
  output logic                   track,
  output logic                   ref_buffers_off,
  output logic [DW-1:0]          db_out,
  output logic                   db_oe,
  output logic                   serial_out
);
  typedef struct packed {
    logic                   busy;
    logic                   track;
    logic [CNT_W-1:0]       cnt;
    logic [NPAIR-1:0]       pairs;
    logic [NPAIR-1:0]       start_prev;
    logic                   wr_prev;
    logic                   rd_prev;
    logic                   sclk_prev;
    logic [CTRL_W-1:0]      ctrl;
    logic [NCH-1:0][DW-1:0] res;
    logic [NCH*DW-1:0]      sreg;
    logic                   push;
    logic [2:0]             idx;
    logic                   byte_ph;
    logic                   buf_off;
    logic [DW-1:0]          dout;
    logic                   oe;
  } sac_st_t;

  sac_st_t          s, n;
  logic [NPAIR-1:0] starts, start_rise, sel;
  logic             start_go, rd_done, sclk_fall, sel_high;
  logic             f_clear, f_in_valid, f_in_ready, f_out_valid, f_out_ready;
  logic [DW-1:0]    f_out_data, head_word;

  assign starts = {start_pair_c, start_pair_b, start_pair_a};

  sac_fifo #(
    .W(DW),
    .D(FIFO_DEPTH)
  ) u_fifo (
    .clock    (clock),
    .nrst     (nrst),
    .clk_en   (clk_en),
    .clear    (f_clear),
    .in_valid (f_in_valid),
    .in_ready (f_in_ready),
    .in_data  (s.res[s.idx]),
    .out_valid(f_out_valid),
    .out_ready(f_out_ready),
    .out_data (f_out_data)
  );

  always_comb begin
    n           = s;
    f_clear     = 1'b0;
    f_in_valid  = 1'b0;
    f_out_ready = 1'b0;
    start_rise  = starts & ~s.start_prev;
    // In software mode only the first start input fires, with the pair choice from the control bits.
    sel         = soft_mode ? s.ctrl[CTRL_PAIR_LSB +: NPAIR] : start_rise;
    start_go    = soft_mode ? start_rise[0] : (|start_rise);
    rd_done     = !s.rd_prev && rd_n && !cs_n && !interface_select;
    sclk_fall   = s.sclk_prev && !sclk;
    sel_high    = s.byte_ph ? !high_byte_first : high_byte_first;
    head_word   = f_out_valid ? f_out_data : '0;
    if (clk_en) begin
      n.start_prev = starts;
      n.wr_prev    = wr_n;
      n.rd_prev    = rd_n;
      n.sclk_prev  = sclk;
      if (!cs_n && rd_n && !s.wr_prev && wr_n) begin
        n.ctrl = db_in[DB_CTRL_LSB +: CTRL_W];
      end
      // Ascending order: skipped pairs are stepped over without a word.
      if (s.push) begin
        f_in_valid = s.pairs[s.idx[2:1]];
        if (!f_in_valid || f_in_ready) begin
          if (s.idx == 3'(IDX_LAST)) begin
            n.push = 1'b0;
          end else begin
            n.idx = 3'(s.idx + 1'b1);
          end
        end
      end
      if (rd_done && f_out_valid) begin
        if (!word_byte_sel || s.byte_ph) begin
          f_out_ready = 1'b1;
          n.byte_ph   = 1'b0;
        end else begin
          n.byte_ph = 1'b1;
        end
      end
      if (interface_select && !cs_n && sclk_fall) begin
        n.sreg = {s.sreg[NCH*DW-2:0], daisy_en & daisy_in};
      end
      if (!s.busy && start_go) begin
        n.busy    = 1'b1;
        n.track   = 1'b0;
        n.cnt     = '0;
        n.pairs   = sel;
        n.push    = 1'b0;
        n.byte_ph = 1'b0;
        // Stale words from the previous cycle must not be read after this one.
        f_clear   = 1'b1;
      end else if (s.busy) begin
        if (s.cnt == CNT_W'(CONV_CYCLES - 1)) begin
          n.busy  = 1'b0;
          n.track = 1'b1;
          for (int i = 0; i < NCH; i++) begin
            n.res[i] = s.pairs[i/2] ? (sample_data[i*DW +: DW] & RES_MASK) : '0;
            n.sreg[(NCH-1-i)*DW +: DW] = n.res[i];
          end
          n.push = !interface_select;
          n.idx  = '0;
        end else begin
          n.cnt = CNT_W'(s.cnt + 1'b1);
        end
      end
      n.oe      = !cs_n && !rd_n && !interface_select;
      n.dout    = !word_byte_sel ? head_word :
                  {(sel_high ? head_word[15:8] : head_word[7:0]), 8'h00};
      n.buf_off = soft_mode ? s.ctrl[CTRL_BUF_BIT] : (interface_select && buffer_disable_pin);
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      s       <= '0;
      s.track <= 1'b1;
      s.ctrl  <= CTRL_RESET;
    end else begin
      s <= n;
    end
  end

  assign busy            = s.busy;
  assign track           = s.track;
  assign ref_buffers_off = s.buf_off;
  assign db_out          = s.dout;
  assign db_oe           = s.oe;
  assign serial_out      = s.sreg[NCH*DW-1];

  localparam int CONV_MIN = 8;
  localparam int CONV_MAX = 1000;

  // The window starts after eight busy cycles, so a conversion shorter than eight cycles fails here as well.
  sequence seq_conv_run;
    s.busy [*8] ##[CONV_MIN:CONV_MAX] !s.busy;
  endsequence

  sequence seq_conv_end;
    !s.busy && s.track;
  endsequence

  chk_conv_time: assert property (@(posedge clock) disable iff (!nrst)
    $rose(s.busy) |-> seq_conv_run)
    else $error("conversion ended too early or too late");

  chk_start_busy: assert property (@(posedge clock) disable iff (!nrst)
    clk_en && !s.busy && start_go |=> s.busy && !s.track && s.cnt == '0)
    else $error("start edge did not begin a conversion");

  chk_busy_ignore: assert property (@(posedge clock) disable iff (!nrst)
    s.busy && s.cnt != CNT_W'(CONV_CYCLES - 1) |=> s.busy && $stable(s.pairs))
    else $error("start edge disturbed a running conversion");

  chk_busy_fall: assert property (@(posedge clock) disable iff (!nrst)
    clk_en && s.busy && s.cnt == CNT_W'(CONV_CYCLES - 1) |=> seq_conv_end)
    else $error("busy did not fall at conversion end");

  chk_track_return: assert property (@(posedge clock) disable iff (!nrst)
    $fell(s.busy) |-> s.track ##1 (s.track || s.busy))
    else $error("hold stage not returned to track");

  chk_serial_zero: assert property (@(posedge clock) disable iff (!nrst)
    $fell(s.busy) |-> (s.pairs[0] || s.sreg[95:64] == '0) && (s.pairs[1] || s.sreg[63:32] == '0)
                      && (s.pairs[2] || s.sreg[31:0] == '0))
    else $error("unconverted serial slot not zero");

  chk_push_sel: assert property (@(posedge clock) disable iff (!nrst)
    f_in_valid |-> s.pairs[s.idx[2:1]] && s.push && !s.busy)
    else $error("word queued for unconverted channel");

  chk_bus_drive: assert property (@(posedge clock) disable iff (!nrst)
    clk_en |=> s.oe == $past(!cs_n && !rd_n && !interface_select))
    else $error("data bus enable wrong");

  chk_buf_off: assert property (@(posedge clock) disable iff (!nrst)
    clk_en && !soft_mode && interface_select && buffer_disable_pin |=> s.buf_off)
    else $error("buffer disable pin ignored");

  chk_ctrl_write: assert property (@(posedge clock) disable iff (!nrst)
    clk_en && !cs_n && rd_n && !s.wr_prev && wr_n |=> s.ctrl == $past(db_in[15:8]))
    else $error("control write not latched");

  chk_ctrl_hold: assert property (@(posedge clock) disable iff (!nrst)
    !(clk_en && !cs_n && rd_n && !s.wr_prev && wr_n) |=> $stable(s.ctrl))
    else $error("control register changed without a write");

  chk_conv_len: assert property (@(posedge clock) disable iff (!nrst)
    $fell(s.busy) |-> $past(s.cnt) == CNT_W'(CONV_CYCLES - 1))
    else $error("conversion length wrong");

  chk_track_low: assert property (@(posedge clock) disable iff (!nrst)
    s.busy |-> !s.track)
    else $error("tracking during conversion");

  chk_idle_track: assert property (@(posedge clock) disable iff (!nrst)
    !s.busy |-> s.track)
    else $error("holding while idle");

  chk_pairs_hw: assert property (@(posedge clock) disable iff (!nrst)
    clk_en && !soft_mode && !s.busy && start_go |=> s.pairs == $past(start_rise))
    else $error("pair set differs from start edges");

  chk_pairs_soft: assert property (@(posedge clock) disable iff (!nrst)
    clk_en && soft_mode && !s.busy && start_go |=> s.pairs == $past(s.ctrl[CTRL_PAIR_LSB +: NPAIR]))
    else $error("pair set differs from control bits");

  chk_all_six: assert property (@(posedge clock) disable iff (!nrst)
    clk_en && !soft_mode && !s.busy && start_rise == 3'h7 |=> s.pairs == 3'h7)
    else $error("tied starts did not select all pairs");

  chk_res_zero: assert property (@(posedge clock) disable iff (!nrst)
    $fell(s.busy) |-> (s.pairs[0] || s.res[1:0] == '0) && (s.pairs[1] || s.res[3:2] == '0)
                      && (s.pairs[2] || s.res[5:4] == '0))
    else $error("unconverted result not zero");

  // Results may only change at the end of a conversion, never while they wait to be read.
  chk_res_hold: assert property (@(posedge clock) disable iff (!nrst)
    !$fell(s.busy) |-> $stable(s.res))
    else $error("held result changed");

  // A new start flushes the queue so that no stale word of the last cycle is read.
  chk_fifo_clear: assert property (@(posedge clock) disable iff (!nrst)
    clk_en && !s.busy && start_go |=> !f_out_valid)
    else $error("queue not flushed at start");

  chk_serial_par: assert property (@(posedge clock) disable iff (!nrst)
    clk_en && interface_select |=> !s.oe)
    else $error("parallel bus driven in serial mode");

  chk_serial_shift: assert property (@(posedge clock) disable iff (!nrst)
    clk_en && interface_select && !cs_n && sclk_fall && !s.busy
    |=> s.sreg[0] == $past(daisy_en && daisy_in))
    else $error("daisy bit not shifted in");

  chk_serial_hold: assert property (@(posedge clock) disable iff (!nrst)
    !sclk_fall && !s.busy |=> $stable(s.sreg))
    else $error("shift register moved without a clock");

  // A byte-mode word takes two completed reads: the first flips the phase, the second pops.
  sequence seq_first_byte;
    clk_en && rd_done && f_out_valid && word_byte_sel && !s.byte_ph && !(start_go && !s.busy);
  endsequence

  sequence seq_phase_set;
    s.byte_ph;
  endsequence

  chk_byte_phase: assert property (@(posedge clock) disable iff (!nrst)
    seq_first_byte |=> seq_phase_set)
    else $error("first byte read did not advance phase");

  chk_byte_pop: assert property (@(posedge clock) disable iff (!nrst)
    clk_en && rd_done && f_out_valid && word_byte_sel && s.byte_ph |-> f_out_ready)
    else $error("second byte read did not pop");

  chk_byte_low: assert property (@(posedge clock) disable iff (!nrst)
    clk_en && word_byte_sel |=> s.dout[7:0] == 8'h00)
    else $error("byte mode drives low lines");

  chk_word_mode: assert property (@(posedge clock) disable iff (!nrst)
    clk_en && !word_byte_sel |=> s.dout == $past(head_word))
    else $error("word mode data wrong");

  chk_empty_zero: assert property (@(posedge clock) disable iff (!nrst)
    clk_en && !f_out_valid && !word_byte_sel |=> s.dout == '0)
    else $error("empty queue gave data");

  chk_buf_hw_par: assert property (@(posedge clock) disable iff (!nrst)
    clk_en && !soft_mode && !interface_select |=> !s.buf_off)
    else $error("buffers off in parallel hardware mode");

  chk_buf_soft: assert property (@(posedge clock) disable iff (!nrst)
    clk_en && soft_mode |=> s.buf_off == $past(s.ctrl[CTRL_BUF_BIT]))
    else $error("buffer control bit ignored");

  // Words are queued strictly one channel after the next, never skipping back.
  chk_order: assert property (@(posedge clock) disable iff (!nrst)
    clk_en && s.push && s.idx != 3'(IDX_LAST) && (!f_in_valid || f_in_ready)
    |=> s.idx == 3'($past(s.idx) + 3'h1))
    else $error("channel order broken");

  chk_no_push_busy: assert property (@(posedge clock) disable iff (!nrst)
    s.busy |-> !s.push)
    else $error("results queued before busy fell");

  chk_push_end: assert property (@(posedge clock) disable iff (!nrst)
    clk_en && s.busy && s.cnt == CNT_W'(CONV_CYCLES - 1) && !interface_select |=> s.push && s.idx == '0)
    else $error("queue fill not started at conversion end");

  chk_serial_nopush: assert property (@(posedge clock) disable iff (!nrst)
    clk_en && s.busy && s.cnt == CNT_W'(CONV_CYCLES - 1) && interface_select |=> !s.push)
    else $error("parallel queue filled in serial mode");
endmodule : sac_conv_ctrl

// [hw/sac_pkg.sv]
// Shared constants for the six-channel conversion control block.
package sac_pkg;
  localparam int DW            = 16;
  localparam int NCH           = 6;
  localparam int NPAIR         = 3;
  localparam int RES_BITS      = 16;
  localparam int FIFO_DEPTH    = 8;
  localparam int CLK_PERIOD_PS = 4000;
  localparam int CONV_TIME_US  = 3;
  localparam int CONV_CYCLES   = (CONV_TIME_US * 1000 * 1000) / CLK_PERIOD_PS;
  localparam int CNT_W         = 10;
  localparam int IDX_LAST      = NCH - 1;
  localparam int CTRL_W        = 8;
  localparam int DB_CTRL_LSB   = 8;
  localparam int CTRL_PAIR_LSB = 5;
  localparam int CTRL_BUF_BIT  = 0;
  localparam logic [CTRL_W-1:0] CTRL_RESET = 8'h00;
  localparam logic [DW-1:0] RES_MASK = 16'((32'h1 << RES_BITS) - 32'h1);
endpackage : sac_pkg

// [hw/sac_fifo.sv]
// Result FIFO with valid and ready on both sides.
`timescale 1ns/1ps
module sac_fifo #(
  parameter int W = 16,
  parameter int D = 8
) (
  input  wire logic         clock,
  input  wire logic         nrst,
  input  wire logic         clk_en,
  input  wire logic         clear,
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data
);
  localparam int AW = $clog2(D);
  typedef struct packed {
    logic [D-1:0][W-1:0] mem;
    logic [AW-1:0]       wp;
    logic [AW-1:0]       rp;
    logic [AW:0]         cnt;
  } sac_fifo_st_t;
  sac_fifo_st_t s, n;
  logic push, pop;

  assign in_ready  = (s.cnt != (AW+1)'(D));
  assign out_valid = (s.cnt != '0);
  assign out_data  = s.mem[s.rp];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_comb begin
    n = s;
    if (clk_en) begin
      if (clear) begin
        n.wp  = '0;
        n.rp  = '0;
        n.cnt = '0;
      end else begin
        if (push) begin
          n.mem[s.wp] = in_data;
          n.wp = (s.wp == AW'(D-1)) ? '0 : AW'(s.wp + 1'b1);
        end
        if (pop) begin
          n.rp = (s.rp == AW'(D-1)) ? '0 : AW'(s.rp + 1'b1);
        end
        n.cnt = (AW+1)'(s.cnt + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop});
      end
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      s <= '0;
    end else begin
      s <= n;
    end
  end
endmodule : sac_fifo

// [verification/sac_host_model.sv]
// Host model: pulses the start inputs and runs parallel and serial transfers.
`timescale 1ns/1ps
module sac_host_model
  import sac_pkg::*;
(
  input  wire logic          clock,
  input  wire logic [DW-1:0] db_out,
  input  wire logic          serial_out,
  output logic [2:0]         start,
  output logic               cs_n,
  output logic               rd_n,
  output logic               wr_n,
  output logic [DW-1:0]      db_in,
  output logic               sclk
);
  initial begin
    start = 3'h0;
    cs_n  = 1'h1;
    rd_n  = 1'h1;
    wr_n  = 1'h1;
    db_in = 16'h5A5A;
    sclk  = 1'h0;
  end

  // Starts idle low, so each pulse is a rise followed by the fall that arms the next one.
  task automatic pulse(input logic [2:0] mask);
    @(posedge clock);
    start <= mask;
    @(posedge clock);
    start <= 3'h0;
  endtask : pulse

  // The read strobe rises while select is still low, so the pop is taken.
  task automatic read_word(output logic [DW-1:0] data);
    @(posedge clock);
    cs_n <= 1'h0;
    rd_n <= 1'h0;
    repeat (2) @(posedge clock);
    #1 data = db_out;
    @(posedge clock);
    rd_n <= 1'h1;
    @(posedge clock);
    cs_n <= 1'h1;
    repeat (2) @(posedge clock);
  endtask : read_word

  task automatic write_ctrl(input logic [7:0] val);
    @(posedge clock);
    cs_n  <= 1'h0;
    wr_n  <= 1'h0;
    db_in <= {val, 8'h00};
    @(posedge clock);
    wr_n <= 1'h1;
    @(posedge clock);
    cs_n  <= 1'h1;
    db_in <= ~db_in;
  endtask : write_ctrl

  task automatic frame(output logic [103:0] fr);
    @(posedge clock);
    cs_n <= 1'h0;
    repeat (2) @(posedge clock);
    for (int i = 103; i >= 0; i--) begin
      #1 fr[i] = serial_out;
      @(posedge clock);
      sclk <= 1'h1;
      @(posedge clock);
      sclk <= 1'h0;
      repeat (2) @(posedge clock);
    end
    cs_n <= 1'h1;
  endtask : frame
endmodule : sac_host_model

// [verification/testbench.sv]
// Self-checking testbench for the conversion control block.
`timescale 1ns/1ps
module testbench
  import sac_pkg::*;
;
  logic              clock, nrst, soft_mode, interface_select, word_byte_sel, high_byte_first;
  logic              buffer_disable_pin, daisy_en, daisy_in, busy, track, ref_buffers_off, db_oe;
  logic              cs_n, rd_n, wr_n, sclk, serial_out, clk_en;
  logic [2:0]        start;
  logic [DW-1:0]     db_in, db_out, rd;
  logic [NCH*DW-1:0] sd;
  logic [103:0]      fr;
  int                num_errors, comparisons;

  sac_conv_ctrl uut (.clock(clock), .nrst(nrst), .clk_en(clk_en), .start_pair_a(start[0]),
    .start_pair_b(start[1]), .start_pair_c(start[2]), .soft_mode(soft_mode),
    .interface_select(interface_select), .word_byte_sel(word_byte_sel),
    .high_byte_first(high_byte_first), .cs_n(cs_n), .rd_n(rd_n), .wr_n(wr_n), .db_in(db_in),
    .buffer_disable_pin(buffer_disable_pin), .sample_data(sd), .sclk(sclk), .daisy_en(daisy_en),
    .daisy_in(daisy_in), .busy(busy), .track(track), .ref_buffers_off(ref_buffers_off),
    .db_out(db_out), .db_oe(db_oe), .serial_out(serial_out));
  sac_host_model host (.clock(clock), .db_out(db_out), .serial_out(serial_out), .start(start),
    .cs_n(cs_n), .rd_n(rd_n), .wr_n(wr_n), .db_in(db_in), .sclk(sclk));

  function automatic logic [DW-1:0] ch(input int n);
    return sd[16*(n-1) +: 16];
  endfunction : ch

  task automatic check(input logic [DW-1:0] seen, input logic [DW-1:0] exp);
    comparisons++;
    if (seen !== exp) begin
      num_errors++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic conclude();
    $display("Errors %0d, comparisons %0d", num_errors, comparisons);
    if (num_errors == 0 && comparisons > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : conclude

  // A second pulse of all pairs mid-conversion must change neither timing nor result set.
  task automatic convert(input logic [2:0] mask);
    time tr;
    int  n;
    host.pulse(mask);
    tr = $time;
    n = 0;
    do begin @(posedge clock); #1 n++; end while (busy !== 1'b1 && n < 10);
    check(DW'(track), 16'h0000);
    host.pulse(3'h7);
    do begin @(posedge clock); #1 n++; end while (busy !== 1'b0 && n < 1000);
    check(DW'(($time - tr) / 4), 16'(CONV_CYCLES));
    check(DW'(track), 16'h0001);
    repeat (10) @(posedge clock);
  endtask : convert

  task automatic t_par_word();
    convert(3'h5);
    for (int i = 0; i < 4; i++) begin
      host.read_word(rd);
      check(rd, ch(i < 2 ? i + 1 : i + 3));
    end
    check(DW'(db_oe), 16'h0000);
    host.read_word(rd);
    check(rd, 16'h0000);
  endtask : t_par_word

  task automatic t_byte();
    logic [DW-1:0] w;
    word_byte_sel   <= 1'h1;
    high_byte_first <= 1'h1;
    convert(3'h7);
    for (int i = 0; i < 12; i++) begin
      host.read_word(rd);
      w = ch(i/2+1);
      check(rd, (i % 2) ? {w[7:0], 8'h00} : {w[15:8], 8'h00});
    end
    word_byte_sel <= 1'h0;
  endtask : t_byte

  task automatic t_serial();
    interface_select   <= 1'h1;
    buffer_disable_pin <= 1'h1;
    daisy_en           <= 1'h1;
    daisy_in           <= 1'h1;
    convert(3'h2);
    check(DW'(ref_buffers_off), 16'h0001);
    host.frame(fr);
    for (int i = 0; i < 6; i++) check(fr[103-16*i -: 16], (i == 2 || i == 3) ? ch(i+1) : 16'h0000);
    check(DW'(fr[7:0]), 16'h00FF);
    interface_select <= 1'h0;
    repeat (3) @(posedge clock);
    check(DW'(ref_buffers_off), 16'h0000);
  endtask : t_serial

  task automatic t_soft();
    soft_mode <= 1'h1;
    host.write_ctrl(8'h21);
    repeat (3) @(posedge clock);
    check(DW'(ref_buffers_off), 16'h0001);
    // A write while the clock enable is low must not reach the control register.
    clk_en <= 1'b0;
    host.write_ctrl(8'h00);
    clk_en <= 1'b1;
    repeat (3) @(posedge clock);
    check(DW'(ref_buffers_off), 16'h0001);
    convert(3'h1);
    for (int i = 1; i <= 3; i++) begin
      host.read_word(rd);
      check(rd, i < 3 ? ch(i) : 16'h0000);
    end
  endtask : t_soft

  initial begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end

  initial begin
    #200000;
    num_errors++;
    conclude();
  end

  initial begin
    nrst = 1'b0; soft_mode = 1'b0; interface_select = 1'b0; word_byte_sel = 1'b0; clk_en = 1'b1;
    high_byte_first = 1'b0; buffer_disable_pin = 1'b0; daisy_en = 1'b0; daisy_in = 1'b0;
    sd = {16'hF666, 16'h5555, 16'hC444, 16'h3333, 16'hA222, 16'h1111};
    num_errors = 0;
    comparisons = 0;
    repeat (3) @(posedge clock);
    nrst <= 1'b1;
    t_par_word();
    t_byte();
    t_serial();
    t_soft();
    conclude();
  end
endmodule : testbench
